// *** gcm_ghash_gf128_engine_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gh_consts.svh"

module gcm_ghash_gf128_engine_tb_top;
  logic clk_i, resetn_i, we_i, re_i, subkey_valid_i, irq_o, subkey_req_o, rd_d;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [255:0] key_o;
  logic [1:0] key_size_o;
  logic [127:0] subkey_i, h, a, b, c, acc, k;
  logic [127:0] expq[$];
  int error_cnt, checks, seed, i;

  gh_engine i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .subkey_req_o(subkey_req_o),
    .key_o(key_o), .key_size_o(key_size_o), .subkey_valid_i(subkey_valid_i), .subkey_i(subkey_i));

  // ==========================================================================
  // Clock, helpers and reference model
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Bit-serial reference, deliberately unlike any fast hardware form
  function automatic logic [127:0] gf_mul(input logic [127:0] x, input logic [127:0] y);
    logic [127:0] z, v;
    z = '0;
    v = y;
    for (int n = 127; n >= 0; n--) begin
      if (x[n]) z ^= v;
      v = v[0] ? ((v >> 1) ^ `GH_POLY_R) : (v >> 1);
    end
    return z;
  endfunction
  function automatic logic [127:0] r128();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  task cmp(input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task test_done;
    if (expq.size() != 0) error_cnt++;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Register port driver; each task sets both strobes so none is set twice
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    re_i <= 1'b0;
    addr_i <= ad;
    wdata_i <= d;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk_i);
    we_i <= 1'b0;
    re_i <= 1'b1;
    addr_i <= ad;
    expq.push_back(128'(e));
  endtask
  task idle;
    @(posedge clk_i);
    we_i <= 1'b0;
    re_i <= 1'b0;
  endtask
  // Word 0 carries the leftmost bits of a block
  task wblk(input logic [7:0] base, input logic [127:0] v);
    for (int n = 0; n < 4; n++) wr(base + 8'(4 * n), 32'(v >> (96 - 32 * n)));
  endtask
  // Last word first, so a read directly follows the last write
  task rblk(input logic [7:0] base, input logic [127:0] e);
    for (int n = 3; n >= 0; n--) rd(base + 8'(4 * n), 32'(e >> (96 - 32 * n)));
  endtask
  task wait_for(input bit use_irq);
    int n;
    idle;
    n = 0;
    // Look between edges only, never in the launching edge's time step
    while (n < 400) begin
      @(negedge clk_i);
      if ((use_irq ? irq_o : subkey_req_o) === 1'b1) break;
      n++;
    end
    if (n == 400) begin
      error_cnt++;
      test_done;
    end
  endtask

  // Read checker: data stand only in the cycle after the strobe
  always @(posedge clk_i) rd_d <= re_i;
  always @(negedge clk_i) if (rd_d === 1'b1 && expq.size() > 0) cmp(expq.pop_front(), 128'(rdata_o));

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 44357;
    error_cnt = 0;
    checks = 0;
    {resetn_i, we_i, re_i, subkey_valid_i} = '0;
    addr_i = '0;
    wdata_i = '0;
    subkey_i = '0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`GH_OFF_MODE, 32'h0);
    rd(8'hfc, 32'h0);
    wr(`GH_OFF_MODE, 32'h2000);
    rd(`GH_OFF_MODE, 32'h2000);
    wr(`GH_OFF_ENABLE, 32'h1);
    for (i = 0; i < 4; i++) begin
      k[32 * i +: 32] = $random(seed);
      wr(8'h20 + 8'(4 * i), k[32 * i +: 32]);
    end
    // Testbench stands in for the cipher core
    h = r128();
    wait_for(1'b0);
    cmp(k, key_o[127:0]);
    @(posedge clk_i) subkey_valid_i <= 1'b1;
    subkey_i <= h;
    @(posedge clk_i) subkey_valid_i <= 1'b0;
    wait_for(1'b1);
    rd(`GH_OFF_STATUS, 32'h1);
    rblk(8'h50, h);
    wr(`GH_OFF_CLEAR, 32'h3);
    // Hash-only pass over two blocks, manual start, seeded accumulator
    wr(`GH_OFF_AUTH_LEN, 32'h20);
    wr(`GH_OFF_CLENGTH, 32'h0);
    c = r128();
    wblk(8'h60, c);
    acc = c;
    for (i = 0; i < 2; i++) begin
      a = r128();
      wblk(8'h40, a);
      wr(`GH_OFF_CTRL, 32'h1);
      rd(`GH_OFF_STATUS, 32'h100);
      acc = gf_mul(acc ^ a, h);
      wait_for(1'b1);
      rd(`GH_OFF_STATUS, i == 1 ? 32'h3 : 32'h1);
      wr(`GH_OFF_CLEAR, 32'h3);
    end
    rblk(8'h60, acc);
    // Single multiply in auto start with C preloaded
    wr(`GH_OFF_MODE, 32'h2100);
    wr(`GH_OFF_AUTH_LEN, 32'h10);
    wr(`GH_OFF_CLENGTH, 32'h0);
    b = r128();
    wblk(8'h50, b);
    rblk(8'h50, b);
    c = r128();
    wblk(8'h60, c);
    a = r128();
    wblk(8'h40, a);
    wait_for(1'b1);
    rblk(8'h60, gf_mul(a ^ c, b));
    wr(`GH_OFF_CLEAR, 32'h3);
    // Non-zero cipher length must not run a hash step
    wr(`GH_OFF_ENABLE, 32'h0);
    wr(`GH_OFF_CLENGTH, 32'h10);
    wr(`GH_OFF_AUTH_LEN, 32'h10);
    wr(`GH_OFF_ENABLE, 32'h3);
    wblk(8'h40, r128());
    repeat (140) idle;
    @(negedge clk_i);
    cmp(128'(0), 128'(irq_o));
    rd(`GH_OFF_STATUS, 32'h0);
    rblk(8'h60, gf_mul(a ^ c, b));
    idle;
    repeat (3) @(posedge clk_i);
    test_done;
  end
endmodule
`default_nettype wire

// *** gh_consts.svh ***
// Summary of operation
// (R1) With a zero ciphertext length the engine only hashes the authenticated data blocks.
// (R2) Software selects the Galois/Counter mode and clears auto tag generation before any input.
// (R3) Writing the key words starts subkey generation and data ready is raised when it completes.
// (R4) After generation the hash subkey can be read and overwritten with any value by software.
// (R5) In manual or auto start mode data ready is raised after every finished hash step.
// (R6) The accumulated hash value is readable from the accumulator registers when processing ends.
// (R7) The accumulator accepts writes at any time and a written value seeds the following steps. Here a write during a hash step is lost to the product.
// (R8) A single 128-bit Galois field multiply is one hash step with a software-given subkey.
// (R9) For one multiply software programs a 16-byte authenticated length and zero cipher length.
// (R10) For A times B software loads B as the subkey, then writes A as the input block.
// (R11) In multiply use data ready flags completion of the single step in manual or auto mode.
// (R12) With C held in the accumulator before A is written, the result is (A xor C) times B.
// (R13) Each step sets the accumulator to subkey times (accumulator xor input) in GCM bit order.
`ifndef GH_CONSTS_SVH
`define GH_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses) and address group codes
`define GH_OFF_CTRL 8'h00
`define GH_OFF_MODE 8'h04
`define GH_OFF_STATUS 8'h08
`define GH_OFF_CLEAR 8'h0c
`define GH_OFF_ENABLE 8'h10
`define GH_OFF_AUTH_LEN 8'h14
`define GH_OFF_CLENGTH 8'h18
`define GH_GRP_KEY 3'h1
`define GH_GRP_INPUT 4'h4
`define GH_GRP_SUBKEY 4'h5
`define GH_GRP_ACC 4'h6

// ==========================================================================
// Field positions and encodings
`define GH_CTRL_START 0
`define GH_MODE_TAG 1
`define GH_MODE_START_LO 8
`define GH_MODE_KSZ_LO 10
`define GH_MODE_OP_LO 12
`define GH_OP_GCM 3'h2
`define GH_START_MANUAL 2'h0
`define GH_START_AUTO 2'h1
`define GH_STATUS_BUSY 8

// ==========================================================================
// Reset values and constants
`define GH_MODE_RESET 8'h00
`define GH_BLOCK_BYTES 32'h0000000f
`define GH_POLY_R 128'he1000000000000000000000000000000
`define GH_MUL_STEPS 8'h7f

`endif

// *** gh_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gh_consts.svh"

module gh_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Interrupt
  output logic irq_o,
  // Block cipher core for subkey generation
  output logic subkey_req_o,
  output logic [255:0] key_o,
  output logic [1:0] key_size_o,
  input wire logic subkey_valid_i,
  input wire logic [127:0] subkey_i
);

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;

  // Two stages so the release is clean against clk_i
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // Internal logic runs from the released copy only
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // Helpers

  // Word 0 is the leftmost 32 bits of a block
  function automatic logic [31:0] gh_word(input logic [127:0] blk, input logic [1:0] idx);
    case (idx)
      2'h0: gh_word = blk[127:96];
      2'h1: gh_word = blk[95:64];
      2'h2: gh_word = blk[63:32];
      default: gh_word = blk[31:0];
    endcase
  endfunction

  // Replace one word of a block
  function automatic logic [127:0] gh_put(input logic [127:0] blk, input logic [1:0] idx,
                                          input logic [31:0] w);
    logic [127:0] r;
    r = blk;
    case (idx)
      2'h0: r[127:96] = w;
      2'h1: r[95:64] = w;
      2'h2: r[63:32] = w;
      default: r[31:0] = w;
    endcase
    gh_put = r;
  endfunction

  // Index of the key word whose write completes the key
  function automatic logic [2:0] gh_last_key(input logic [1:0] size);
    case (size)
      2'h0: gh_last_key = 3'h3;
      2'h1: gh_last_key = 3'h5;
      default: gh_last_key = 3'h7;
    endcase
  endfunction

  // Count of 16-byte blocks, a partial last block counts as one
  function automatic logic [28:0] gh_blocks(input logic [31:0] len);
    logic [32:0] sum;
    sum = {1'b0, len} + {1'b0, `GH_BLOCK_BYTES};
    gh_blocks = sum[32:4];
  endfunction

  // Address falls into one 16-byte group of four words
  function automatic logic gh_hit(input logic [7:0] addr, input logic [3:0] grp);
    gh_hit = (addr[7:4] == grp);
  endfunction

  // ==========================================================================
  // Field multiplier
  // Register and sequencing state
  gh_pkg::gh_core_type s;
  gh_pkg::gh_core_type next_s;
  logic mul_busy;
  logic mul_done;
  logic [127:0] mul_z;

  // Operands are sampled on the start cycle, so a write at the trigger still counts
  gh_gfmul u_gfmul (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(s.mul_start),
    .x_i(s.acc ^ s.in_block), // R12
    .h_i(s.subkey), // R8
    .busy_o(mul_busy),
    .done_o(mul_done),
    .z_o(mul_z)
  );

  // ==========================================================================
  // Decode and sequencing

  // Per-cycle decode results
  gh_pkg::gh_event_type ev;
  gh_pkg::gh_event_type clr;
  logic start_req;
  logic mode_ok;
  logic len_ok;
  logic can_hash;
  logic [3:0] mask;
  logic [1:0] widx;

  always_comb begin
    next_s = s;
    ev = '0;
    clr = '0;
    start_req = 1'b0;
    mask = s.in_mask;
    widx = addr_i[3:2];
    next_s.subkey_req = 1'b0;
    next_s.mul_start = 1'b0;
    next_s.rdata = '0;

    // Hashing is only allowed in the GCM hash-only setup
    mode_ok = (s.mode.op_mode == `GH_OP_GCM) && !s.mode.auto_tag;
    // No encryption path, so a non-zero cipher length refuses the block
    len_ok = (s.ciphertext_length == 32'h0) && (s.blocks_left != 29'h0); // R1
    can_hash = mode_ok && len_ok;

    // ==========================================================================
    // Register writes
    if (we_i) begin
      case (addr_i)
        // Start strobe only counts in manual start mode
        `GH_OFF_CTRL: begin
          start_req = wdata_i[`GH_CTRL_START] && (s.mode.start_mode == `GH_START_MANUAL);
        end
        // Mode fields, unused bits dropped
        `GH_OFF_MODE: begin
          next_s.mode.op_mode = wdata_i[`GH_MODE_OP_LO +: 3];
          next_s.mode.key_size = wdata_i[`GH_MODE_KSZ_LO +: 2];
          next_s.mode.start_mode = wdata_i[`GH_MODE_START_LO +: 2];
          next_s.mode.auto_tag = wdata_i[`GH_MODE_TAG];
        end
        // Ones clear status bits
        `GH_OFF_CLEAR: begin
          clr = wdata_i[1:0];
        end
        // Interrupt sources
        `GH_OFF_ENABLE: begin
          next_s.enable = wdata_i[1:0];
        end
        // Length also reloads the block count
        `GH_OFF_AUTH_LEN: begin
          next_s.aad_len = wdata_i;
          next_s.blocks_left = gh_blocks(wdata_i); // R1
        end
        // Cipher length only gates hashing
        `GH_OFF_CLENGTH: begin
          next_s.ciphertext_length = wdata_i;
        end
        // Key, input, subkey and accumulator words
        default: begin
          if (addr_i[7:5] == `GH_GRP_KEY) begin
            next_s.key[addr_i[4:2]] = wdata_i;
            // Last key word kicks off subkey generation
            if (addr_i[4:2] == gh_last_key(s.mode.key_size) && s.state == gh_pkg::GH_IDLE) begin
              next_s.subkey_req = 1'b1; // R3
              next_s.state = gh_pkg::GH_KEYGEN;
            end
          end else if (gh_hit(addr_i, `GH_GRP_INPUT)) begin
            next_s.in_block = gh_put(s.in_block, widx, wdata_i); // R10
            mask[widx] = 1'b1;
            start_req = (mask == 4'hf) && (s.mode.start_mode != `GH_START_MANUAL);
          end else if (gh_hit(addr_i, `GH_GRP_SUBKEY)) begin
            next_s.subkey = gh_put(s.subkey, widx, wdata_i); // R4
          end else if (gh_hit(addr_i, `GH_GRP_ACC)) begin
            next_s.acc = gh_put(s.acc, widx, wdata_i); // R7
          end
        end
      endcase
    end
    next_s.in_mask = mask;

    // ==========================================================================
    // Register reads, data stand one cycle later
    if (re_i) begin
      case (addr_i)
        // Mode fields back in place
        `GH_OFF_MODE: begin
          next_s.rdata[`GH_MODE_OP_LO +: 3] = s.mode.op_mode;
          next_s.rdata[`GH_MODE_KSZ_LO +: 2] = s.mode.key_size;
          next_s.rdata[`GH_MODE_START_LO +: 2] = s.mode.start_mode;
          next_s.rdata[`GH_MODE_TAG] = s.mode.auto_tag;
        end
        // Sticky bits plus live busy
        `GH_OFF_STATUS: begin
          next_s.rdata[1:0] = s.status;
          next_s.rdata[`GH_STATUS_BUSY] = (s.state != gh_pkg::GH_IDLE);
        end
        // Interrupt sources
        `GH_OFF_ENABLE: begin
          next_s.rdata[1:0] = s.enable;
        end
        // Lengths read back as written
        `GH_OFF_AUTH_LEN: begin
          next_s.rdata = s.aad_len;
        end
        `GH_OFF_CLENGTH: begin
          next_s.rdata = s.ciphertext_length;
        end
        default: begin
          // Key and input words are write-only and read as zero
          if (gh_hit(addr_i, `GH_GRP_SUBKEY)) begin
            next_s.rdata = gh_word(s.subkey, widx); // R4
          end else if (gh_hit(addr_i, `GH_GRP_ACC)) begin
            next_s.rdata = gh_word(s.acc, widx); // R6
          end
        end
      endcase
    end

    // ==========================================================================
    // Engine sequencing
    case (s.state)
      // Waiting for a block or a key
      gh_pkg::GH_IDLE: begin
        if (start_req && can_hash) begin
          next_s.mul_start = 1'b1; // R13
          next_s.in_mask = 4'h0;
          next_s.state = gh_pkg::GH_HASH;
        end else if (start_req) begin
          next_s.in_mask = 4'h0; // Block dropped outside hash setup
        end
      end
      // Cipher core computes the subkey
      gh_pkg::GH_KEYGEN: begin
        // Generated value wins over a software write in the same cycle
        if (subkey_valid_i) begin
          next_s.subkey = subkey_i; // R3
          ev.data_ready = 1'b1; // R3
          next_s.state = gh_pkg::GH_IDLE;
        end
      end
      // One multiply in flight
      gh_pkg::GH_HASH: begin
        if (mul_done) begin
          // Accumulator takes the product, one block counted off
          next_s.acc = mul_z; // R13
          next_s.blocks_left = s.blocks_left - 29'h1;
          ev.data_ready = (s.mode.start_mode == `GH_START_MANUAL)
                          || (s.mode.start_mode == `GH_START_AUTO); // R5 R11
          ev.hash_end = (s.blocks_left == 29'h1); // R6
          next_s.state = gh_pkg::GH_IDLE;
        end
      end
      default: next_s.state = gh_pkg::GH_IDLE;
    endcase

    // A block completed while busy is dropped, not queued for later
    if (start_req && ((s.state != gh_pkg::GH_IDLE) || mul_busy)) begin
      next_s.in_mask = 4'h0;
    end

    // ==========================================================================
    // Sticky status: a new event wins over a clear in the same cycle
    next_s.status = (s.status & ~clr) | ev;
    next_s.irq = |(next_s.status & next_s.enable);
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= `GH_MODE_RESET;
      s.state <= gh_pkg::GH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign subkey_req_o = s.subkey_req;
  // Key words and size go to the cipher core as held
  assign key_o = s.key;
  assign key_size_o = s.mode.key_size;

endmodule
`default_nettype wire

// *** gh_engine_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gh_consts.svh"

// ==========================================================================
// Port checker for the hash engine
module gh_engine_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  // Interrupt
  input wire logic irq_o,
  // Cipher core side
  input wire logic subkey_req_o,
  input wire logic [255:0] key_o,
  input wire logic [1:0] key_size_o,
  input wire logic subkey_valid_i,
  input wire logic [127:0] subkey_i
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_RDATA_IDLE: assert property (!$past(re_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  AST_REQ_PULSE: assert property (subkey_req_o |=> !subkey_req_o)
    else $error("subkey request longer than one cycle");
  AST_REQ_CAUSE: assert property ($rose(subkey_req_o) |-> $past(we_i) && $past(addr_i[7:5]) == 3'h1)
    else $error("subkey request without a key write");
  AST_KEY_WORD: assert property (we_i && addr_i == 8'h20 |=> key_o[31:0] == $past(wdata_i))
    else $error("key word not taken");
  AST_KEYSIZE: assert property (we_i && addr_i == `GH_OFF_MODE |=> key_size_o == $past(wdata_i[11:10]))
    else $error("key size does not follow mode");
  AST_IRQ_OFF: assert property (we_i && addr_i == `GH_OFF_ENABLE && wdata_i[1:0] == 2'h0 |-> ##2 !irq_o)
    else $error("interrupt high with all sources disabled");
  AST_MODE_RW: assert property (we_i && addr_i == `GH_OFF_MODE ##1 re_i && addr_i == `GH_OFF_MODE
    |=> rdata_o == ($past(wdata_i, 2) & 32'h00007f02))
    else $error("mode read back wrong");
  // Generation result landing between write and read would legally overwrite
  AST_SUBKEY_RW: assert property (we_i && addr_i == 8'h5c && !subkey_valid_i ##1
    re_i && addr_i == 8'h5c && !subkey_valid_i |=> rdata_o == $past(wdata_i, 2))
    else $error("subkey read back wrong");
  AST_WO_ZERO: assert property (re_i && (addr_i[7:5] == 3'h1 || addr_i[7:4] == 4'h4 || addr_i == 8'hfc)
    |=> rdata_o == 32'h0)
    else $error("write-only or unmapped place read non-zero");
endmodule

bind gh_engine gh_engine_monitor i_mon (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .subkey_req_o(subkey_req_o), .key_o(key_o), .key_size_o(key_size_o),
  .subkey_valid_i(subkey_valid_i), .subkey_i(subkey_i));
`default_nettype wire

// *** gh_gfmul.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gh_consts.svh"

module gh_gfmul (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Operands, taken on start
  input wire logic start_i,
  input wire logic [127:0] x_i,
  input wire logic [127:0] h_i,
  // Result
  output logic busy_o,
  output logic done_o,
  output logic [127:0] z_o
);

  gh_pkg::gh_mul_type s;
  gh_pkg::gh_mul_type next_s;

  // ==========================================================================
  // One bit per cycle, leftmost bit first; 128 cycles trades speed for area
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start_i && !s.busy) begin
      next_s.z = '0;
      next_s.v = h_i;
      next_s.x = x_i;
      next_s.count = 8'h00;
      next_s.busy = 1'b1;
    end else if (s.busy) begin
      if (s.x[127]) begin
        next_s.z = s.z ^ s.v; // R13
      end
      if (s.v[0]) begin
        next_s.v = (s.v >> 1) ^ `GH_POLY_R; // R13
      end else begin
        next_s.v = s.v >> 1;
      end
      next_s.x = s.x << 1;
      next_s.count = s.count + 8'h01;
      if (s.count == `GH_MUL_STEPS) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign done_o = s.done;
  assign z_o = s.z;

endmodule
`default_nettype wire

// *** gh_pkg.sv ***
package gh_pkg;

  // ==========================================================================
  // Engine sequencing
  typedef enum logic [1:0] {GH_IDLE, GH_KEYGEN, GH_HASH} gh_state_type;

  // Mode register fields
  typedef struct packed {
    logic [2:0] op_mode;
    logic [1:0] key_size;
    logic [1:0] start_mode;
    logic auto_tag;
  } gh_mode_type;

  // Sticky event bits, same layout in status, clear and enable
  typedef struct packed {
    logic hash_end;
    logic data_ready;
  } gh_event_type;

  // Whole state of the register and sequencing core
  typedef struct packed {
    gh_state_type state;
    gh_mode_type mode;
    logic [7:0][31:0] key;
    logic [31:0] aad_len;
    logic [31:0] ciphertext_length;
    logic [127:0] in_block;
    logic [3:0] in_mask;
    logic [127:0] subkey;
    logic [127:0] acc;
    logic [28:0] blocks_left;
    gh_event_type status;
    gh_event_type enable;
    logic irq;
    logic [31:0] rdata;
    logic subkey_req;
    logic mul_start;
  } gh_core_type;

  // Whole state of the serial field multiplier
  typedef struct packed {
    logic [127:0] z;
    logic [127:0] v;
    logic [127:0] x;
    logic [7:0] count;
    logic busy;
    logic done;
  } gh_mul_type;

endpackage
